// ### rtl/bfbt_top.sv
// Breaker failure stage with backup trip, counters, force flag and log.
// Summary of operation
// - Backup trip after drive outlasts operation time.
// - Backup trip holds until primary drive releases.
// - Selection 1 supervises first, 2 second output.
// - Supervise the trip output control signal itself.
// - Shared force flag clears after five minutes.
// - Status idle/blocked/start/trip; forcible only when forcing.
// - Settings writable only after correct password.
// - Log eight latest faults with time, delay.
// - Start and trip counters, each clearable.
// - Logged delay is percent; trip is hundred.
//
// Design decisions made here: strobed register access and the register offsets.
module bfbt_top #(
    parameter int unsigned MS_CYCLES        = bfbt_pkg::MS_CYCLES_DEF,
    parameter int unsigned FORCE_TIMEOUT_MS = bfbt_pkg::FORCE_TIMEOUT_MS_DEF,
    parameter logic [31:0] UNLOCK_KEY       = bfbt_pkg::UNLOCK_KEY_DEF
) (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          resetn,
    // Register port
    input  wire logic [bfbt_pkg::ADDR_W-1:0]   regAddr,
    input  wire logic [bfbt_pkg::DATA_W-1:0]   regWdata,
    input  wire logic                          regWr,
    input  wire logic                          regRd,
    output logic      [bfbt_pkg::DATA_W-1:0]   regRdata,
    // Trip output drives and blocking
    input  wire logic                          tripFirstDrive,
    input  wire logic                          tripSecondDrive,
    input  wire logic                          stageBlock,
    // Stage outputs
    output logic                               backupTrip,
    output logic                               stageStart,
    output logic                               stageTrip,
    output logic                               irq
);
    import bfbt_pkg::*;

    // ************************************************************
    // Decoding
    // ************************************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction : hit

    bfbt_log_if logIf ();

    bfbt_state_t        state_reg;
    bfbt_state_t        state_next;
    logic [1:0]         sel_reg;
    logic [15:0]        opTime_reg;
    logic               unlocked_reg;
    logic               force_reg;
    logic               fStart_reg;
    logic               fTrip_reg;
    logic [31:0]        forceCnt_reg;
    logic [31:0]        msPre_reg;
    logic [31:0]        msClock_reg;
    logic [15:0]        elapsed_reg;
    logic [15:0]        sCount_reg;
    logic [15:0]        tCount_reg;
    logic [IRQ_N-1:0]   iStat_reg;
    logic [IRQ_N-1:0]   iMask_reg;
    logic [2:0]         logSel_reg;
    logic [31:0]        rdata_reg;
    logic               backup_reg;
    logic               start_reg;
    logic               trip_reg;
    logic               irq_reg;

    logic               wrSel, wrOpt, wrUnl, wrFrc, wrSta;
    logic               wrSc, wrTc, wrMsk, wrLog, rdIst;
    logic               msTick;
    logic               supDrive;
    logic               supActive;
    logic               reached;
    logic               enterStart;
    logic               enterTrip;
    logic               logFault;
    logic               forceTimeout;
    logic [22:0]        pctWide;
    logic [7:0]         pctNow;
    logic [IRQ_N-1:0]   iEvent;
    logic [31:0]        rdMux;

    assign wrSel = regWr && hit(regAddr, OFS_SELECT) && unlocked_reg;
    assign wrOpt = regWr && hit(regAddr, OFS_OPTIME) && unlocked_reg;
    assign wrFrc = regWr && hit(regAddr, OFS_FORCE) && unlocked_reg;
    assign wrUnl = regWr && hit(regAddr, OFS_UNLOCK);
    assign wrSta = regWr && hit(regAddr, OFS_STATUS) && force_reg;
    assign wrSc  = regWr && hit(regAddr, OFS_SCOUNT);
    assign wrTc  = regWr && hit(regAddr, OFS_TCOUNT);
    assign wrMsk = regWr && hit(regAddr, OFS_IMASK);
    assign wrLog = regWr && hit(regAddr, OFS_LOGSEL);
    assign rdIst = regRd && hit(regAddr, OFS_ISTAT);

    // ************************************************************
    // Supervision and timing
    // ************************************************************
    // The relay drive is watched rather than any one protection stage, so
    // every stage routed to that output is covered without extra wiring.
    assign supDrive   = (sel_reg == SEL_SECOND) ? tripSecondDrive
                                                : tripFirstDrive;
    assign supActive  = supDrive || fStart_reg || fTrip_reg;
    assign msTick     = (msPre_reg == 32'(MS_CYCLES - 1));
    assign reached    = (elapsed_reg >= opTime_reg) || fTrip_reg;
    assign forceTimeout = force_reg &&
                          (forceCnt_reg >= 32'(FORCE_TIMEOUT_MS));

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE, ST_BLOCKED: begin
                if (stageBlock) begin
                    state_next = ST_BLOCKED;
                end else if (supActive) begin
                    state_next = ST_START;
                end else begin
                    state_next = ST_IDLE;
                end
            end
            ST_START: begin
                if (!supActive) begin
                    state_next = ST_IDLE;
                end else if (reached) begin
                    state_next = ST_TRIP;
                end
            end
            ST_TRIP: begin
                if (!supActive) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    assign enterStart = (state_reg != ST_START) && (state_reg != ST_TRIP) &&
                        (state_next == ST_START);
    assign enterTrip  = (state_reg == ST_START) && (state_next == ST_TRIP);
    assign logFault   = (state_reg == ST_START) && (state_next != ST_START);

    // A zero operation time counts as an instant trip, so percent is full.
    assign pctWide = (opTime_reg == 16'h0) ? 23'(PCT_FULL) :
                     (({7'h0, elapsed_reg} * 23'd100) / {7'h0, opTime_reg});
    assign pctNow  = (pctWide >= 23'(PCT_FULL)) ? PCT_FULL
                                                : pctWide[7:0];

    assign logIf.wrEn   = logFault;
    assign logIf.wrTime = msClock_reg;
    assign logIf.wrPct  = enterTrip ? PCT_FULL : pctNow;
    assign logIf.rdIdx  = logSel_reg;

    bfbt_fault_log u_log (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .logIf   (logIf)
    );

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_reg   <= ST_IDLE;
            msPre_reg   <= '0;
            msClock_reg <= '0;
            elapsed_reg <= '0;
        end else begin
            state_reg   <= state_next;
            msPre_reg   <= msTick ? 32'h0 : msPre_reg + 32'h1;
            msClock_reg <= msClock_reg + {31'h0, msTick};
            if (state_next != ST_START && state_next != ST_TRIP) begin
                elapsed_reg <= '0;
            end else if (state_reg == ST_START && msTick &&
                         elapsed_reg != 16'hffff) begin
                elapsed_reg <= elapsed_reg + 16'h1;
            end
        end
    end

    // ************************************************************
    // Settings, force flag and counters
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sel_reg      <= SEL_RST;
            opTime_reg   <= OPTIME_RST;
            unlocked_reg <= 1'b0;
            force_reg    <= 1'b0;
            forceCnt_reg <= '0;
            fStart_reg   <= 1'b0;
            fTrip_reg    <= 1'b0;
        end else begin
            if (wrSel && (regWdata[1:0] == SEL_FIRST ||
                          regWdata[1:0] == SEL_SECOND)) begin
                sel_reg <= regWdata[1:0];
            end
            if (wrOpt) begin
                opTime_reg <= regWdata[15:0];
            end
            if (wrUnl) begin
                unlocked_reg <= (regWdata == UNLOCK_KEY);
            end
            if (forceTimeout) begin
                force_reg <= 1'b0;
            end else if (wrFrc) begin
                force_reg <= regWdata[FORCE_BIT];
            end
            forceCnt_reg <= !force_reg ? 32'h0 :
                            forceCnt_reg + {31'h0, msTick};
            // Forced states vanish with the flag, so a forgotten test
            // cannot leave the backup trip energised.
            if (!force_reg || forceTimeout) begin
                fStart_reg <= 1'b0;
                fTrip_reg  <= 1'b0;
            end else if (wrSta) begin
                fStart_reg <= regWdata[FST_START_BIT];
                fTrip_reg  <= regWdata[FST_TRIP_BIT];
            end
        end
    end

    // An event in the clearing cycle still counts, leaving the count at one.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sCount_reg <= '0;
            tCount_reg <= '0;
        end else begin
            sCount_reg <= (wrSc ? 16'h0 : sCount_reg) +
                          {15'h0, enterStart};
            tCount_reg <= (wrTc ? 16'h0 : tCount_reg) +
                          {15'h0, enterTrip};
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    assign iEvent[IRQ_START] = enterStart;
    assign iEvent[IRQ_TRIP]  = enterTrip;
    assign iEvent[IRQ_FTO]   = forceTimeout;

    for (genvar i = 0; i < IRQ_N; i++) begin : g_istat
        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                iStat_reg[i] <= 1'b0;
            end else if (iEvent[i]) begin
                iStat_reg[i] <= 1'b1;
            end else if (rdIst) begin
                iStat_reg[i] <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Read path and outputs
    // ************************************************************
    always_comb begin
        rdMux = '0;
        case (regAddr)
            OFS_SELECT: rdMux = {30'h0, sel_reg};
            OFS_OPTIME: rdMux = {16'h0, opTime_reg};
            OFS_UNLOCK: rdMux = {31'h0, unlocked_reg};
            OFS_FORCE:  rdMux = {31'h0, force_reg};
            OFS_STATUS: rdMux = {28'h0, fTrip_reg, fStart_reg, state_reg};
            OFS_SCOUNT: rdMux = {16'h0, sCount_reg};
            OFS_TCOUNT: rdMux = {16'h0, tCount_reg};
            OFS_ISTAT:  rdMux = {29'h0, iStat_reg};
            OFS_IMASK:  rdMux = {29'h0, iMask_reg};
            OFS_LOGSEL: rdMux = {29'h0, logSel_reg};
            OFS_LOGTIM: rdMux = logIf.rdTime;
            OFS_LOGPCT: rdMux = {23'h0, logIf.rdValid, logIf.rdPct};
            default:    rdMux = '0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            iMask_reg  <= '0;
            logSel_reg <= '0;
            rdata_reg  <= '0;
            backup_reg <= 1'b0;
            start_reg  <= 1'b0;
            trip_reg   <= 1'b0;
            irq_reg    <= 1'b0;
        end else begin
            if (wrMsk) begin
                iMask_reg <= regWdata[IRQ_N-1:0];
            end
            if (wrLog) begin
                logSel_reg <= regWdata[2:0];
            end
            rdata_reg  <= regRd ? rdMux : 32'h0;
            backup_reg <= (state_next == ST_TRIP);
            start_reg  <= (state_next == ST_START) || (state_next == ST_TRIP);
            trip_reg   <= (state_next == ST_TRIP);
            irq_reg    <= |((iStat_reg | iEvent) & iMask_reg);
        end
    end

    assign regRdata   = rdata_reg;
    assign backupTrip = backup_reg;
    assign stageStart = start_reg;
    assign stageTrip  = trip_reg;
    assign irq        = irq_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_tripping;
        state_reg == ST_TRIP && supActive;
    endsequence
    sequence s_released;
        !backup_reg && state_reg == ST_IDLE;
    endsequence

    a_trip_on_delay: assert property (
        state_reg == ST_START && supActive && reached
        |=> backup_reg && state_reg == ST_TRIP)
        else $error("Backup trip missing after delay");
    a_backup_hold: assert property (
        s_tripping |=> backup_reg)
        else $error("Backup trip dropped while primary active");
    a_backup_release: assert property (
        state_reg == ST_TRIP && !supActive |=> s_released)
        else $error("Backup trip held after primary release");
    a_select_source: assert property (
        state_reg == ST_IDLE && !fStart_reg && !fTrip_reg &&
        ((sel_reg == SEL_FIRST && !tripFirstDrive) ||
         (sel_reg == SEL_SECOND && !tripSecondDrive))
        |=> !stageStart)
        else $error("Wrong trip output supervised");
    a_force_expiry: assert property (
        force_reg && forceCnt_reg >= 32'(FORCE_TIMEOUT_MS)
        |=> !force_reg && !fTrip_reg && iStat_reg[IRQ_FTO])
        else $error("Force flag outlived its timeout");
    a_status_guard: assert property (
        regWr && hit(regAddr, OFS_STATUS) && !force_reg
        |=> !fStart_reg && !fTrip_reg)
        else $error("Status forced without force flag");
    a_lock_guard: assert property (
        regWr && hit(regAddr, OFS_OPTIME) && !unlocked_reg
        |=> $stable(opTime_reg))
        else $error("Locked setting changed");
    a_log_trip: assert property (
        enterTrip |-> logIf.wrEn && logIf.wrPct == PCT_FULL)
        else $error("Trip not logged at full percent");
    a_count_clear: assert property (
        regWr && hit(regAddr, OFS_TCOUNT) && !enterTrip
        |=> tCount_reg == 16'h0)
        else $error("Trip counter not cleared");
    a_timer_restart: assert property (
        state_reg == ST_START && !supActive
        |=> elapsed_reg == 16'h0 [*2])
        else $error("Delay timer not restarted");

endmodule : bfbt_top

// ### pkg/bfbt_pkg.sv
// Shared constants and types of the breaker failure backup trip block.
package bfbt_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int unsigned CLK_HZ               = 40_000_000;
    localparam int unsigned MS_PER_S             = 1000;
    localparam int unsigned MS_CYCLES_DEF        = CLK_HZ / MS_PER_S;
    localparam int unsigned S_PER_MIN            = 60;
    localparam int unsigned FORCE_TIMEOUT_MIN    = 5;
    localparam int unsigned FORCE_TIMEOUT_MS_DEF =
        FORCE_TIMEOUT_MIN * S_PER_MIN * MS_PER_S;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 32;
    localparam logic [7:0]  OFS_SELECT = 8'h00;
    localparam logic [7:0]  OFS_OPTIME = 8'h04;
    localparam logic [7:0]  OFS_UNLOCK = 8'h08;
    localparam logic [7:0]  OFS_FORCE  = 8'h0c;
    localparam logic [7:0]  OFS_STATUS = 8'h10;
    localparam logic [7:0]  OFS_SCOUNT = 8'h14;
    localparam logic [7:0]  OFS_TCOUNT = 8'h18;
    localparam logic [7:0]  OFS_ISTAT  = 8'h1c;
    localparam logic [7:0]  OFS_IMASK  = 8'h20;
    localparam logic [7:0]  OFS_LOGSEL = 8'h24;
    localparam logic [7:0]  OFS_LOGTIM = 8'h28;
    localparam logic [7:0]  OFS_LOGPCT = 8'h2c;

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam logic [1:0]  SEL_FIRST      = 2'h1;
    localparam logic [1:0]  SEL_SECOND     = 2'h2;
    localparam logic [1:0]  SEL_RST        = 2'h1;
    localparam logic [15:0] OPTIME_RST     = 16'h00c8;
    localparam logic [31:0] UNLOCK_KEY_DEF = 32'h5a5a_c3c3; // Arbitrary.
    localparam int          FORCE_BIT      = 0;
    localparam int          FST_START_BIT  = 2;
    localparam int          FST_TRIP_BIT   = 3;
    localparam int          LOCK_OK_BIT    = 0;
    localparam int          IRQ_START      = 0;
    localparam int          IRQ_TRIP       = 1;
    localparam int          IRQ_FTO        = 2;
    localparam int          IRQ_N          = 3;
    localparam int          LOG_VALID_BIT  = 8;
    localparam logic [7:0]  PCT_FULL       = 8'h64;
    localparam int          LOG_DEPTH      = 8;
    localparam int          LOG_IDX_W      = 3;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_START   = 2'b01,
        ST_TRIP    = 2'b11,
        ST_BLOCKED = 2'b10
    } bfbt_state_t;

endpackage : bfbt_pkg

// ### pkg/bfbt_log_if.sv
// Interface between the stage logic and its fault log.
interface bfbt_log_if;
    logic        wrEn;
    logic [31:0] wrTime;
    logic [7:0]  wrPct;
    logic [2:0]  rdIdx;
    logic [31:0] rdTime;
    logic [7:0]  rdPct;
    logic        rdValid;

    modport writer (output wrEn, wrTime, wrPct, rdIdx,
                    input  rdTime, rdPct, rdValid);
    modport store  (input  wrEn, wrTime, wrPct, rdIdx,
                    output rdTime, rdPct, rdValid);
endinterface : bfbt_log_if

// ### rtl/bfbt_fault_log.sv
// Ring store of the latest faults, read back newest first.
module bfbt_fault_log (
    // Clock and reset
    input wire logic    sys_clk,
    input wire logic    resetn,
    // Log port
    bfbt_log_if.store   logIf
);
    import bfbt_pkg::*;

    logic [31:0]          timeMem [LOG_DEPTH];
    logic [7:0]           pctMem  [LOG_DEPTH];
    logic [LOG_IDX_W-1:0] wrPtr_reg;
    logic [LOG_IDX_W:0]   fill_reg;
    logic [LOG_IDX_W-1:0] rdAddr;

    // Index 0 is the newest entry, so software never tracks the pointer.
    assign rdAddr        = wrPtr_reg - 3'h1 - logIf.rdIdx;
    assign logIf.rdTime  = timeMem[rdAddr];
    assign logIf.rdPct   = pctMem[rdAddr];
    assign logIf.rdValid = {1'b0, logIf.rdIdx} < fill_reg;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wrPtr_reg <= '0;
            fill_reg  <= '0;
        end else if (logIf.wrEn) begin
            wrPtr_reg <= wrPtr_reg + 3'h1;
            if (fill_reg != 4'(LOG_DEPTH)) begin
                fill_reg <= fill_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (logIf.wrEn) begin
            timeMem[wrPtr_reg] <= logIf.wrTime;
            pctMem[wrPtr_reg]  <= logIf.wrPct;
        end
    end

endmodule : bfbt_fault_log

// ### test/bfbt_stage_model.sv
// Model of the protection stages that drive the two trip outputs.
module bfbt_stage_model (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // Stage trips; a set routing bit sends that stage to the second output
    input  wire logic [1:0] stageFire,
    input  wire logic [1:0] routeSecond,
    // Trip output control signals
    output logic            tripFirstDrive,
    output logic            tripSecondDrive
);
    timeunit 1ns;
    timeprecision 100ps;

    // Several stages may share one output, so supervision sees them all.
    // The backup trip is wired to its own contact, never to these two.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tripFirstDrive  <= 1'b0;
            tripSecondDrive <= 1'b0;
        end else begin
            tripFirstDrive  <= |(stageFire & ~routeSecond);
            tripSecondDrive <= |(stageFire & routeSecond);
        end
    end
endmodule : bfbt_stage_model

// ### test/tb_breaker_failure_backup_trip.sv
// Self-checking bench of the breaker failure backup trip block.
module tb_breaker_failure_backup_trip;
    timeunit 1ns;
    timeprecision 100ps;
    import bfbt_pkg::*;

    // Design and model connections
    logic        sys_clk     = 1'b0;
    logic        resetn      = 1'b0;
    logic [7:0]  regAddr     = 8'h00;
    logic [31:0] regWdata    = 32'h0;
    logic        regWr       = 1'b0;
    logic        regRd       = 1'b0;
    logic [1:0]  stageFire   = 2'h0;
    logic [1:0]  routeSecond = 2'h0;
    logic        stageBlock  = 1'b0;
    logic [31:0] regRdata;
    logic        tripFirstDrive, tripSecondDrive;
    logic        backupTrip, stageStart, stageTrip, irq;
    int          numErrors   = 0;
    int          checksDone  = 0;
    logic [31:0] rv;

    // Short counts keep the five minute timeout inside a brief run.
    bfbt_top #(.MS_CYCLES(4), .FORCE_TIMEOUT_MS(10)) u_dut (
        .sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .tripFirstDrive(tripFirstDrive),
        .tripSecondDrive(tripSecondDrive), .stageBlock(stageBlock),
        .backupTrip(backupTrip), .stageStart(stageStart),
        .stageTrip(stageTrip), .irq(irq));
    bfbt_stage_model u_model (
        .sys_clk(sys_clk), .resetn(resetn), .stageFire(stageFire),
        .routeSecond(routeSecond), .tripFirstDrive(tripFirstDrive),
        .tripSecondDrive(tripSecondDrive));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc

    task automatic chkWord(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            numErrors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chkWord

    task automatic chkBit(input string what, input logic exp,
                          input logic got);
        chkWord(what, {31'h0, exp}, {31'h0, got});
    endtask : chkBit

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
        #1;
    endtask : wr

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp,
                         input string what);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 rv = regRdata;
        chkWord(what, exp, rv);
    endtask : rdChk

    task automatic waitTrip();
        for (int i = 0; i < 14 && backupTrip !== 1'b1; i++) cyc(1);
    endtask : waitTrip

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic testReset();
        rdChk(OFS_SELECT, 32'h1, "select");
        rdChk(OFS_OPTIME, 32'hc8, "optime");
        rdChk(8'h30, 32'h0, "unmapped");
        wr(OFS_SELECT, 32'h2);
        wr(OFS_OPTIME, 32'h9);
        rdChk(OFS_SELECT, 32'h1, "select locked");
        rdChk(OFS_OPTIME, 32'hc8, "optime locked");
        wr(OFS_UNLOCK, UNLOCK_KEY_DEF);
        rdChk(OFS_UNLOCK, 32'h1, "unlocked");
        wr(OFS_OPTIME, 32'h3);
        wr(OFS_IMASK, 32'h7);
        $display("test reset done");
    endtask : testReset

    task automatic testTrip();
        stageFire <= 2'h1;
        cyc(10);
        chkBit("start", 1'b1, stageStart);
        chkBit("early backup", 1'b0, backupTrip);
        waitTrip();
        chkBit("backup", 1'b1, backupTrip);
        cyc(20);
        chkBit("backup held", 1'b1, backupTrip);
        chkBit("trip", 1'b1, stageTrip);
        chkBit("irq", 1'b1, irq);
        rdChk(OFS_ISTAT, 32'h3, "istat");
        cyc(2);
        chkBit("irq clear", 1'b0, irq);
        stageFire <= 2'h0;
        cyc(4);
        chkBit("backup off", 1'b0, backupTrip);
        rdChk(OFS_SCOUNT, 32'h1, "scount");
        rdChk(OFS_TCOUNT, 32'h1, "tcount");
        wr(OFS_LOGSEL, 32'h0);
        rdChk(OFS_LOGPCT, 32'h164, "log pct");
        $display("test trip done");
    endtask : testTrip

    task automatic testSelect();
        wr(OFS_SELECT, 32'h2);
        stageFire <= 2'h1;
        cyc(8);
        chkBit("other output", 1'b0, stageStart);
        stageFire   <= 2'h0;
        cyc(3);
        routeSecond <= 2'h2;
        stageFire   <= 2'h2;
        cyc(9);
        chkBit("second start", 1'b1, stageStart);
        stageFire <= 2'h0;
        cyc(3);
        stageFire <= 2'h2;
        cyc(10);
        chkBit("restart", 1'b0, backupTrip);
        waitTrip();
        chkBit("second trip", 1'b1, backupTrip);
        stageFire <= 2'h0;
        cyc(4);
        wr(OFS_LOGSEL, 32'h1);
        rdChk(OFS_LOGPCT, 32'h142, "log order");
        chkBit("early entry", 1'b1, rv[8]);
        wr(OFS_LOGSEL, 32'h2);
        rdChk(OFS_LOGPCT, 32'h164, "log oldest");
        rdChk(OFS_SCOUNT, 32'h3, "scount 3");
        wr(OFS_SCOUNT, 32'h0);
        wr(OFS_TCOUNT, 32'h0);
        rdChk(OFS_SCOUNT, 32'h0, "scount clr");
        rdChk(OFS_TCOUNT, 32'h0, "tcount clr");
        $display("test select done");
    endtask : testSelect

    task automatic testForce();
        stageBlock <= 1'b1;
        cyc(3);
        rdChk(OFS_STATUS, 32'h2, "blocked");
        stageBlock <= 1'b0;
        cyc(2);
        rdChk(OFS_ISTAT, 32'h3, "istat old");
        wr(OFS_STATUS, 32'h4);
        rdChk(OFS_STATUS, 32'h0, "status lock");
        wr(OFS_FORCE, 32'h1);
        wr(OFS_STATUS, 32'h4);
        cyc(3);
        chkBit("forced start", 1'b1, stageStart);
        wr(OFS_STATUS, 32'h8);
        cyc(2);
        chkBit("forced trip", 1'b1, backupTrip);
        cyc(24);
        rdChk(OFS_FORCE, 32'h1, "force held");
        cyc(20);
        rdChk(OFS_FORCE, 32'h0, "force timeout");
        rdChk(OFS_ISTAT, 32'h7, "istat fto");
        cyc(3);
        chkBit("force release", 1'b0, backupTrip);
        $display("test force done");
    endtask : testForce

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checksDone, numErrors);
        if (numErrors == 0 && checksDone > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    // ************************************************************
    // Clock, sequence and watchdog
    // ************************************************************
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial begin
        cyc(8);
        resetn <= 1'b1;
        cyc(1);
        testReset();
        testTrip();
        testSelect();
        testForce();
        tally_and_finish();
    end

    // The tests take well under a thousand cycles; this cuts a hang.
    initial begin
        cyc(3000);
        numErrors++;
        tally_and_finish();
    end
endmodule : tb_breaker_failure_backup_trip
